// file: design/sbdsk_defines.svh
/*
  constants for the subtract-with-borrow and decrement-skip slice:
  widths, flag bit positions, operation codes, state codes, reset values.
  assumes inclusion by bare name from the package and the datapath.
*/
`ifndef SBDSK_DEFINES_SVH
`define SBDSK_DEFINES_SVH

// data path width
`define SBDSK_DATA_W 8
// nibble boundary used by the auxiliary carry
`define SBDSK_NIB_W 4
// number of status flags driven by this slice
`define SBDSK_FLAG_W 6

// flag bit positions inside the flag vectors
`define SBDSK_FLG_C 0
`define SBDSK_FLG_AC 1
`define SBDSK_FLG_Z 2
`define SBDSK_FLG_OV 3
`define SBDSK_FLG_SC 4
`define SBDSK_FLG_CZ 5

// flag write masks
`define SBDSK_MASK_SBC 6'h3F
`define SBDSK_MASK_NONE 6'h00

// operation select codes
`define SBDSK_OP_SBC 1'h0
`define SBDSK_OP_DEC 1'h1

// one-hot state codes
`define SBDSK_ST_IDLE 2'h1
`define SBDSK_ST_DUMMY 2'h2

// reset values
`define SBDSK_RST_DATA 8'h00
`define SBDSK_RST_FLAGS 6'h00

`endif

// file: design/sbdsk_pkg.sv
/*
  types for the subtract-with-borrow and decrement-skip slice.
  assumes sbdsk_defines.svh is on the include path.
*/
`include "sbdsk_defines.svh"

package sbdsk_pkg;
  // operation selector
  typedef enum logic [0:0] {
    SBDSK_SBC = `SBDSK_OP_SBC,
    SBDSK_DEC = `SBDSK_OP_DEC
  } sbdsk_op_t;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    SBDSK_IDLE = `SBDSK_ST_IDLE,
    SBDSK_DUMMY = `SBDSK_ST_DUMMY
  } sbdsk_state_t;
endpackage

// file: design/sbdsk_core.sv
/*
  datapath slice for subtract-with-borrow-to-memory and
  decrement-memory-skip-if-zero, plus the dummy-cycle sequencer.
  assumes the core feeds the accumulator, the memory operand and the
  carry from logic on the same clock, and that it honours READY_O.
*/
// Notes on behaviour
// - memory gets accumulator minus operand minus inverted carry
// - negative difference clears the carry flag
// - zero or positive difference sets carry
// - subtract updates six flags, no others
// - decrement writes operand minus one back
// - zero result skips the next instruction
// - skip inserts one dummy no-effect cycle
// - skip costs two cycles, else continue normally
`timescale 1ns/1ns
`include "sbdsk_defines.svh"

module sbdsk_core #(
  parameter int DATA_W = `SBDSK_DATA_W
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // instruction request
  input wire logic OP_VALID_I,
  input wire sbdsk_pkg::sbdsk_op_t OP_SEL_I,
  // operands
  input wire logic [DATA_W-1:0] ACC_I,
  input wire logic [DATA_W-1:0] MEM_RDATA_I,
  input wire logic CARRY_I,
  input wire logic CARRY_ZERO_I,
  // handshake back to the core
  output logic READY_O,
  // memory write-back
  output logic MEM_WE_O,
  output logic [DATA_W-1:0] MEM_WDATA_O,
  // flag update
  output logic [`SBDSK_FLAG_W-1:0] FLAGS_O,
  output logic [`SBDSK_FLAG_W-1:0] FLAG_WE_O,
  // sequencing
  output logic SKIP_O,
  output logic NOP_INSERT_O
);
  import sbdsk_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  ////////////////////////////////////////////////////////////////////////

  // sequencer state
  sbdsk_state_t state_r;
  sbdsk_state_t state_nxt;
  // output registers
  logic ready_r;
  logic ready_nxt;
  logic mem_we_r;
  logic mem_we_nxt;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wdata_nxt;
  logic [`SBDSK_FLAG_W-1:0] flags_r;
  logic [`SBDSK_FLAG_W-1:0] flags_nxt;
  logic [`SBDSK_FLAG_W-1:0] flag_we_r;
  logic [`SBDSK_FLAG_W-1:0] flag_we_nxt;
  logic skip_r;
  logic skip_nxt;
  logic nop_r;
  logic nop_nxt;
  // request accepted this cycle
  logic take;
  // subtract arithmetic, one spare bit for the borrow
  logic [DATA_W:0] sub_full;
  logic [`SBDSK_NIB_W:0] sub_nib;
  logic [DATA_W-1:0] sub_res;
  logic sub_ov;
  logic sub_z;
  // decrement arithmetic
  logic [DATA_W-1:0] dec_res;
  logic dec_zero;

  ////////////////////////////////////////////////////////////////////////
  // arithmetic
  ////////////////////////////////////////////////////////////////////////

  // only taken while no dummy cycle is pending
  assign take = OP_VALID_I && ready_r;

  // acc minus operand minus inverted carry, borrow in the top bit
  always_comb begin
    sub_full = {1'b0, ACC_I} - {1'b0, MEM_RDATA_I}
               - {{DATA_W{1'b0}}, ~CARRY_I};
    sub_nib = {1'b0, ACC_I[`SBDSK_NIB_W-1:0]}
              - {1'b0, MEM_RDATA_I[`SBDSK_NIB_W-1:0]}
              - {{`SBDSK_NIB_W{1'b0}}, ~CARRY_I};
    sub_res = sub_full[DATA_W-1:0];
    // signed overflow: operand signs differ and result sign flips
    sub_ov = (ACC_I[DATA_W-1] ^ MEM_RDATA_I[DATA_W-1])
             & (ACC_I[DATA_W-1] ^ sub_res[DATA_W-1]);
    sub_z = (sub_res == '0);
  end

  // operand minus one
  always_comb begin
    dec_res = MEM_RDATA_I - {{(DATA_W-1){1'b0}}, 1'b1};
    dec_zero = (dec_res == '0);
  end

  ////////////////////////////////////////////////////////////////////////
  // next-value logic
  ////////////////////////////////////////////////////////////////////////

  // sequencer and output next values
  always_comb begin
    state_nxt = SBDSK_IDLE;
    ready_nxt = 1'b1;
    mem_we_nxt = 1'b0;
    wdata_nxt = wdata_r;
    flags_nxt = flags_r;
    flag_we_nxt = `SBDSK_MASK_NONE;
    skip_nxt = 1'b0;
    nop_nxt = 1'b0;
    case (state_r)
      SBDSK_IDLE: begin
        if (take && OP_SEL_I == SBDSK_SBC) begin
          // write difference back, update the six flags
          mem_we_nxt = 1'b1;
          wdata_nxt = sub_res;
          flags_nxt[`SBDSK_FLG_C] = ~sub_full[DATA_W];
          flags_nxt[`SBDSK_FLG_AC] = ~sub_nib[`SBDSK_NIB_W];
          flags_nxt[`SBDSK_FLG_Z] = sub_z;
          flags_nxt[`SBDSK_FLG_OV] = sub_ov;
          flags_nxt[`SBDSK_FLG_SC] = sub_ov ^ sub_res[DATA_W-1];
          flags_nxt[`SBDSK_FLG_CZ] = sub_z & CARRY_ZERO_I;
          flag_we_nxt = `SBDSK_MASK_SBC;
        end else if (take && OP_SEL_I == SBDSK_DEC) begin
          // write decremented value, flags untouched
          mem_we_nxt = 1'b1;
          wdata_nxt = dec_res;
          if (dec_zero) begin
            // skip: hold off requests for the dummy cycle
            skip_nxt = 1'b1;
            nop_nxt = 1'b1;
            ready_nxt = 1'b0;
            state_nxt = SBDSK_DUMMY;
          end
        end
      end
      SBDSK_DUMMY: begin
        // dummy cycle ends, next request may follow
        state_nxt = SBDSK_IDLE;
      end
      default: begin
        // illegal code recovers to idle
        state_nxt = SBDSK_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  ////////////////////////////////////////////////////////////////////////

  // synchronous active-low reset to constants
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      state_r <= SBDSK_IDLE;
      ready_r <= 1'b1;
      mem_we_r <= 1'b0;
      wdata_r <= `SBDSK_RST_DATA;
      flags_r <= `SBDSK_RST_FLAGS;
      flag_we_r <= `SBDSK_MASK_NONE;
      skip_r <= 1'b0;
      nop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      mem_we_r <= mem_we_nxt;
      wdata_r <= wdata_nxt;
      flags_r <= flags_nxt;
      flag_we_r <= flag_we_nxt;
      skip_r <= skip_nxt;
      nop_r <= nop_nxt;
    end
  end

  // outputs straight from flip-flops
  assign READY_O = ready_r;
  assign MEM_WE_O = mem_we_r;
  assign MEM_WDATA_O = wdata_r;
  assign FLAGS_O = flags_r;
  assign FLAG_WE_O = flag_we_r;
  assign SKIP_O = skip_r;
  assign NOP_INSERT_O = nop_r;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  ////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  // helper: expected subtract result and borrow from raw inputs
  logic [DATA_W:0] chk_sub;
  assign chk_sub = {1'b0, ACC_I} - {1'b0, MEM_RDATA_I}
                   - {{DATA_W{1'b0}}, ~CARRY_I};
  logic sbc_take;
  logic dec_take;
  assign sbc_take = take && OP_SEL_I == SBDSK_SBC;
  assign dec_take = take && OP_SEL_I == SBDSK_DEC;

  AST_SBC_WRITE: assert property (
    sbc_take |=> MEM_WE_O && MEM_WDATA_O == $past(chk_sub[DATA_W-1:0]))
    else $error("subtract result not written back");

  AST_SBC_BORROW: assert property (
    sbc_take && (ACC_I < MEM_RDATA_I + {{DATA_W{1'b0}}, ~CARRY_I})
    |=> !FLAGS_O[`SBDSK_FLG_C])
    else $error("carry not cleared on negative difference");

  AST_SBC_CARRY: assert property (
    sbc_take && ({1'b0, ACC_I} >= {1'b0, MEM_RDATA_I}
                 + {{DATA_W{1'b0}}, ~CARRY_I})
    |=> FLAGS_O[`SBDSK_FLG_C])
    else $error("carry not set on non-negative difference");

  AST_SBC_MASK: assert property (
    sbc_take |=> FLAG_WE_O == `SBDSK_MASK_SBC
      && FLAGS_O[`SBDSK_FLG_Z] == (MEM_WDATA_O == '0))
    else $error("subtract flag mask or zero flag wrong");

  AST_DEC_WRITE: assert property (
    dec_take |=> MEM_WE_O && FLAG_WE_O == `SBDSK_MASK_NONE
      && MEM_WDATA_O == $past(MEM_RDATA_I) - 8'h01)
    else $error("decrement not written back");

  AST_DEC_SKIP: assert property (
    dec_take && MEM_RDATA_I == 8'h01 |=> SKIP_O ##1 !SKIP_O)
    else $error("skip missing or longer than one cycle");

  AST_DUMMY: assert property (
    SKIP_O |-> NOP_INSERT_O && !READY_O ##1 !NOP_INSERT_O && READY_O)
    else $error("dummy cycle not inserted for skip");

  AST_NO_SKIP: assert property (
    dec_take && MEM_RDATA_I != 8'h01 |=> !SKIP_O && !NOP_INSERT_O
      && READY_O)
    else $error("nonzero decrement stalled the sequence");

  AST_TWO_CYCLE: assert property (
    $fell(READY_O) |=> READY_O)
    else $error("dummy stall not exactly one cycle");

  AST_IDLE_QUIET: assert property (
    !take |=> !MEM_WE_O && FLAG_WE_O == `SBDSK_MASK_NONE && !SKIP_O)
    else $error("write or flag update without a request");

  // main scenarios
  COV_SBC_BORROW: cover property (sbc_take ##1 !FLAGS_O[`SBDSK_FLG_C]);
  COV_SBC_CARRY: cover property (sbc_take ##1 FLAGS_O[`SBDSK_FLG_C]);
  COV_DEC_SKIP: cover property (dec_take ##1 SKIP_O ##1 READY_O);
  COV_DEC_NOSKIP: cover property (dec_take ##1 MEM_WE_O && !SKIP_O);
  COV_REFUSED: cover property (OP_VALID_I && !READY_O);

endmodule // sbdsk_core

// file: dv/subtract_borrow_and_decrement_skip_tb.sv
/*
  self-checking bench for the subtract-with-borrow and decrement-skip slice.
  assumes sbdsk_pkg is compiled first; inputs change on the falling edge.
*/
`timescale 1ns/1ns
module subtract_borrow_and_decrement_skip_tb;
  import sbdsk_pkg::*;
  // bench-side signals
  logic clk, nrst, vld, c, cz, rdy, we, skip, nop;
  sbdsk_op_t sel;
  logic [7:0] acc, mem, wd;
  logic [5:0] fl, fwe;
  int num_errors, n_checks;

  ////////////////////////////////////////////////////////////////////////
  // device under test
  sbdsk_core dut (
    .REF_CLK_I(clk), .NRST_I(nrst), .OP_VALID_I(vld), .OP_SEL_I(sel),
    .ACC_I(acc), .MEM_RDATA_I(mem), .CARRY_I(c), .CARRY_ZERO_I(cz),
    .READY_O(rdy), .MEM_WE_O(we), .MEM_WDATA_O(wd), .FLAGS_O(fl),
    .FLAG_WE_O(fwe), .SKIP_O(skip), .NOP_INSERT_O(nop)
  );

  // 250 mhz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // compare and report
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // verdict and end of run
  task summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // present one request from a falling edge, return at the next one
  task issue(input sbdsk_op_t o, input logic [7:0] a, input logic [7:0] m,
             input logic ci, input logic czi);
    sel = o;
    acc = a;
    mem = m;
    c = ci;
    cz = czi;
    vld = 1'b1;
    @(posedge clk);
    @(negedge clk);
  endtask

  // one subtract with expectations worked out bit by bit
  task sbc_case(input logic [7:0] a, input logic [7:0] m, input logic ci,
                input logic czi);
    logic [8:0] d;
    logic [4:0] n;
    logic [5:0] f;
    d = {1'b0, a} - {1'b0, m} - {8'h00, ~ci};
    n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~ci};
    f[0] = ~d[8];
    f[1] = ~n[4];
    f[2] = (d[7:0] == 8'h00);
    f[3] = (a[7] ^ m[7]) & (a[7] ^ d[7]);
    f[4] = f[3] ^ d[7];
    f[5] = f[2] & czi;
    issue(SBDSK_SBC, a, m, ci, czi);
    chk("sbc_wdata", wd, d[7:0]);
    chk("sbc_we", {7'h00, we}, 8'h01);
    chk("sbc_carry", {7'h00, fl[0]}, {7'h00, f[0]});
    chk("sbc_flags", {2'h0, fl}, {2'h0, f});
    chk("sbc_flag_we", {2'h0, fwe}, 8'h3F);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  // idle outputs while reset is held
  task test_reset;
    chk("rst_ready", {7'h00, rdy}, 8'h01);
    chk("rst_we", {5'h00, we, skip, nop}, 8'h00);
  endtask

  // back-to-back subtracts over borrow, zero, overflow and nibble cases
  task test_sbc;
    sbc_case(8'h00, 8'h01, 1'b1, 1'b0);
    sbc_case(8'h05, 8'h05, 1'b1, 1'b1);
    sbc_case(8'h05, 8'h05, 1'b1, 1'b0);
    sbc_case(8'h05, 8'h05, 1'b0, 1'b1);
    sbc_case(8'h80, 8'h01, 1'b1, 1'b0);
    sbc_case(8'h7F, 8'hFF, 1'b1, 1'b0);
    sbc_case(8'h10, 8'h01, 1'b1, 1'b0);
    sbc_case(8'hFF, 8'h00, 1'b0, 1'b0);
    vld = 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("sbc_idle", {1'b0, we, fwe}, 8'h00);
  endtask

  // decrement that leaves a nonzero value, wrap from zero included
  task test_dec_nonzero;
    logic [5:0] held;
    held = fl;
    issue(SBDSK_DEC, 8'hAA, 8'h05, 1'b0, 1'b1);
    chk("dec_wdata", wd, 8'h04);
    chk("dec_flag_we", {2'h0, fwe}, 8'h00);
    chk("dec_noskip", {6'h00, skip, nop}, 8'h00);
    chk("dec_ready", {7'h00, rdy}, 8'h01);
    issue(SBDSK_DEC, 8'h00, 8'h00, 1'b1, 1'b0);
    chk("dec_wrap", wd, 8'hFF);
    chk("dec_we", {7'h00, we}, 8'h01);
    chk("dec_flags", {2'h0, fl}, {2'h0, held});
    chk("dec_noskip2", {6'h00, skip, nop}, 8'h00);
  endtask

  // decrement to zero skips, and a request in the dummy cycle is refused
  task test_dec_zero;
    issue(SBDSK_DEC, 8'h00, 8'h01, 1'b0, 1'b0);
    chk("skip_wdata", wd, 8'h00);
    chk("skip_pulse", {7'h00, skip}, 8'h01);
    chk("skip_nop", {7'h00, nop}, 8'h01);
    chk("skip_busy", {7'h00, rdy}, 8'h00);
    issue(SBDSK_SBC, 8'h55, 8'h11, 1'b1, 1'b1);
    chk("dummy_we", {5'h00, we, skip, nop}, 8'h00);
    chk("dummy_wdata", wd, 8'h00);
    chk("dummy_ready", {7'h00, rdy}, 8'h01);
    // drop the request and let one idle edge pass before the next task
    vld = 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("after_dummy", {5'h00, we, skip, nop}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    num_errors = 0;
    n_checks = 0;
    nrst = 1'b0;
    vld = 1'b0;
    sel = SBDSK_SBC;
    acc = 8'h00;
    mem = 8'h00;
    c = 1'b0;
    cz = 1'b0;
    repeat (8) @(negedge clk);
    test_reset;
    nrst = 1'b1;
    test_sbc;
    test_dec_nonzero;
    test_dec_zero;
    test_sbc;
    summarize;
  end

  // watchdog against a hung run
  initial begin
    #20000;
    num_errors++;
    summarize;
  end
endmodule // subtract_borrow_and_decrement_skip_tb
